// ==== logic/accel_event_regs.v ====
/*
 * Event status and step count register bank of the accelerometer
 * embedded function engine: four read-only source registers, the step
 * threshold configuration register and the step count bytes.
 * Assumes the serial port engine presents a parallel register access
 * (address, read and write strobes) on sys_clk, and that the event
 * detectors are logic on the same clock driving level status bits.
 */
`timescale 1ns/1ps
`default_nettype none
`include "accel_event_consts.vh"

module accel_event_regs
(
    input  wire         sys_clk,
    input  wire         resetn,
    // Register access from the serial port engine
    input  wire [7:0]   reg_addr,
    input  wire         reg_wr_en,
    input  wire [7:0]   reg_wdata,
    input  wire         reg_rd_en,
    output reg  [7:0]   reg_rdata,
    output reg          reg_rd_valid,
    // FIFO and data path status
    input  wire         fifo_overrun_det,
    input  wire         new_sample_det,
    // Wake-up, sleep and free-fall detectors
    input  wire         wakeup_det,
    input  wire         x_wakeup_det,
    input  wire         y_wakeup_det,
    input  wire         z_wakeup_det,
    input  wire         inactivity_det,
    input  wire         freefall_det,
    // Knock detector
    input  wire         knock_det,
    input  wire         single_knock_det,
    input  wire         double_knock_det,
    input  wire         knock_negative_det,
    input  wire         x_knock_det,
    input  wire         y_knock_det,
    input  wire         z_knock_det,
    // Orientation detector
    input  wire         orientation_change_det,
    input  wire         z_high_det,
    input  wire         z_low_det,
    input  wire         y_high_det,
    input  wire         y_low_det,
    input  wire         x_high_det,
    input  wire         x_low_det,
    // Pedometer
    input  wire         step_pulse,
    output reg          step_count_clear,
    output reg          pedometer_wide_range,
    output reg  [5:0]   step_min_threshold,
    output wire [15:0]  step_count
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Address match, shared by the write decode and the read decode
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // ****************************************************************
    // Event flags
    // ****************************************************************

    reg  [`EV_WIDTH-1:0] event_flags_reg;
    reg  [`EV_WIDTH-1:0] event_flags_next;

    // Gather every detector level into one vector; each register view
    // below reads this single copy so duplicated bits never disagree
    always @*
    begin
        event_flags_next = {`EV_WIDTH{1'b0}};
        event_flags_next[`EV_OVERRUN]      = fifo_overrun_det;
        event_flags_next[`EV_NEW_SAMPLE]   = new_sample_det;
        event_flags_next[`EV_WAKEUP]       = wakeup_det;
        event_flags_next[`EV_WAKE_X]       = x_wakeup_det;
        event_flags_next[`EV_WAKE_Y]       = y_wakeup_det;
        event_flags_next[`EV_WAKE_Z]       = z_wakeup_det;
        event_flags_next[`EV_SLEEP]        = inactivity_det;
        event_flags_next[`EV_FREEFALL]     = freefall_det;
        // Any kind of knock also raises the summary flag
        event_flags_next[`EV_KNOCK_ANY]    = knock_det | single_knock_det | double_knock_det;
        event_flags_next[`EV_KNOCK_SINGLE] = single_knock_det;
        event_flags_next[`EV_KNOCK_DOUBLE] = double_knock_det;
        event_flags_next[`EV_KNOCK_NEG]    = knock_negative_det;
        event_flags_next[`EV_KNOCK_X]      = x_knock_det;
        event_flags_next[`EV_KNOCK_Y]      = y_knock_det;
        event_flags_next[`EV_KNOCK_Z]      = z_knock_det;
        event_flags_next[`EV_ORIENT_CHG]   = orientation_change_det;
        event_flags_next[`EV_X_LOW]        = x_low_det;
        event_flags_next[`EV_X_HIGH]       = x_high_det;
        event_flags_next[`EV_Y_LOW]        = y_low_det;
        event_flags_next[`EV_Y_HIGH]       = y_high_det;
        event_flags_next[`EV_Z_LOW]        = z_low_det;
        event_flags_next[`EV_Z_HIGH]       = z_high_det;
    end

    // Flag register; reads never touch it, so nothing clears on read
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            event_flags_reg <= {`EV_WIDTH{1'b0}};
        end
        else
        begin
            event_flags_reg <= event_flags_next;
        end
    end

    // Named views of the shared flag vector
    wire fifo_overrun_flag       = event_flags_reg[`EV_OVERRUN];
    wire new_sample_flag         = event_flags_reg[`EV_NEW_SAMPLE];
    wire wakeup_event_flag       = event_flags_reg[`EV_WAKEUP];
    wire x_axis_wakeup_flag      = event_flags_reg[`EV_WAKE_X];
    wire y_axis_wakeup_flag      = event_flags_reg[`EV_WAKE_Y];
    wire z_axis_wakeup_flag      = event_flags_reg[`EV_WAKE_Z];
    wire inactivity_event_flag   = event_flags_reg[`EV_SLEEP];
    wire freefall_flag           = event_flags_reg[`EV_FREEFALL];
    wire any_knock_flag          = event_flags_reg[`EV_KNOCK_ANY];
    wire single_knock_flag       = event_flags_reg[`EV_KNOCK_SINGLE];
    wire double_knock_flag       = event_flags_reg[`EV_KNOCK_DOUBLE];
    wire knock_negative_flag     = event_flags_reg[`EV_KNOCK_NEG];
    wire x_knock_flag            = event_flags_reg[`EV_KNOCK_X];
    wire y_knock_flag            = event_flags_reg[`EV_KNOCK_Y];
    wire z_knock_flag            = event_flags_reg[`EV_KNOCK_Z];
    wire orientation_change_flag = event_flags_reg[`EV_ORIENT_CHG];
    wire x_low_over              = event_flags_reg[`EV_X_LOW];
    wire x_high_over             = event_flags_reg[`EV_X_HIGH];
    wire y_low_over              = event_flags_reg[`EV_Y_LOW];
    wire y_high_over             = event_flags_reg[`EV_Y_HIGH];
    wire z_low_over              = event_flags_reg[`EV_Z_LOW];
    wire z_high_over             = event_flags_reg[`EV_Z_HIGH];

    // ****************************************************************
    // Register images
    // ****************************************************************

    wire [7:0] event_status_mirror;
    wire [7:0] wakeup_source;
    wire [7:0] knock_source;
    wire [7:0] orientation_source;
    wire [7:0] step_threshold_config;

    // Mirror: overrun down to data-ready, all from the shared vector
    assign event_status_mirror = {fifo_overrun_flag,
                                  wakeup_event_flag,
                                  inactivity_event_flag,
                                  double_knock_flag,
                                  single_knock_flag,
                                  orientation_change_flag,
                                  freefall_flag,
                                  new_sample_flag};

    // Wake-up source: two unused bits read zero
    assign wakeup_source = {2'b00,
                            freefall_flag,
                            inactivity_event_flag,
                            wakeup_event_flag,
                            x_axis_wakeup_flag,
                            y_axis_wakeup_flag,
                            z_axis_wakeup_flag};

    // Knock source: top bit unused
    assign knock_source = {1'b0,
                           any_knock_flag,
                           single_knock_flag,
                           double_knock_flag,
                           knock_negative_flag,
                           x_knock_flag,
                           y_knock_flag,
                           z_knock_flag};

    // Orientation source: top bit unused
    assign orientation_source = {1'b0,
                                 orientation_change_flag,
                                 z_high_over,
                                 z_low_over,
                                 y_high_over,
                                 y_low_over,
                                 x_high_over,
                                 x_low_over};

    // Configuration image reads back exactly what was stored
    assign step_threshold_config = {step_count_clear,
                                    pedometer_wide_range,
                                    step_min_threshold};

    // ****************************************************************
    // Step threshold configuration register
    // ****************************************************************

    wire cfg_write = reg_wr_en & addr_hit(reg_addr, `OFS_STEP_THRESHOLD_CFG);

    // Writes to the read-only offsets fall through and are dropped
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            step_count_clear     <= 1'b0;
            pedometer_wide_range <= 1'b0;
            step_min_threshold   <= `STC_THRESH_RESET;
        end
        else if (cfg_write)
        begin
            step_count_clear     <= reg_wdata[`STC_CLEAR_BIT];
            pedometer_wide_range <= reg_wdata[`STC_WIDE_BIT];
            step_min_threshold   <= reg_wdata[`STC_THRESH_MSB:0];
        end
    end

    // ****************************************************************
    // Step counter
    // ****************************************************************

    // The clear bit is a level: while it stays 1 the count is held at
    // zero, so software must write it back to 0 to resume counting
    step_tally u_step_tally
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .step_pulse (step_pulse),
        .clear      (step_count_clear),
        .count      (step_count)
    );

    wire [7:0] step_count_low_byte  = step_count[7:0];
    wire [7:0] step_count_high_byte = step_count[15:8];

    // High byte snapshot taken when the low byte is read, so a low then
    // high read pair never tears across a carry between the two reads
    reg  [7:0] high_snapshot_reg;
    reg        snapshot_valid_reg;

    wire low_read  = reg_rd_en & addr_hit(reg_addr, `OFS_STEP_COUNT_LOW);
    wire high_read = reg_rd_en & addr_hit(reg_addr, `OFS_STEP_COUNT_HIGH);

    // Snapshot capture and release
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            high_snapshot_reg  <= 8'h00;
            snapshot_valid_reg <= 1'b0;
        end
        else if (low_read)
        begin
            high_snapshot_reg  <= step_count_high_byte;
            snapshot_valid_reg <= 1'b1;
        end
        else if (high_read | step_count_clear)
        begin
            snapshot_valid_reg <= 1'b0;
        end
    end

    // A lone high read with no prior low read returns the live byte
    wire [7:0] high_view = snapshot_valid_reg ? high_snapshot_reg : step_count_high_byte;

    // ****************************************************************
    // Read path
    // ****************************************************************

    localparam RD_IDLE = 1'b0;
    localparam RD_RESP = 1'b1;

    reg        rd_state_reg;
    reg        rd_state_next;
    reg  [7:0] rd_data_next;

    // Read multiplexer; unmapped offsets answer zero
    always @*
    begin
        rd_data_next = 8'h00;
        if (addr_hit(reg_addr, `OFS_EVENT_STATUS_MIRROR))
        begin
            rd_data_next = event_status_mirror;
        end
        else if (addr_hit(reg_addr, `OFS_WAKEUP_SOURCE))
        begin
            rd_data_next = wakeup_source;
        end
        else if (addr_hit(reg_addr, `OFS_KNOCK_SOURCE))
        begin
            rd_data_next = knock_source;
        end
        else if (addr_hit(reg_addr, `OFS_ORIENTATION_SOURCE))
        begin
            rd_data_next = orientation_source;
        end
        else if (addr_hit(reg_addr, `OFS_STEP_THRESHOLD_CFG))
        begin
            rd_data_next = step_threshold_config;
        end
        else if (addr_hit(reg_addr, `OFS_STEP_COUNT_LOW))
        begin
            rd_data_next = step_count_low_byte;
        end
        else if (addr_hit(reg_addr, `OFS_STEP_COUNT_HIGH))
        begin
            rd_data_next = high_view;
        end
    end

    // Response state: one answer cycle after each accepted read
    always @*
    begin
        case (rd_state_reg)
            RD_IDLE:
            begin
                rd_state_next = reg_rd_en ? RD_RESP : RD_IDLE;
            end
            RD_RESP:
            begin
                rd_state_next = reg_rd_en ? RD_RESP : RD_IDLE;
            end
            default:
            begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // Read data and valid registers; data holds until the next read
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rd_state_reg <= RD_IDLE;
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            rd_state_reg <= rd_state_next;
            reg_rd_valid <= rd_state_next;
            if (reg_rd_en)
            begin
                reg_rdata <= rd_data_next;
            end
        end
    end

endmodule
`default_nettype wire

// ==== logic/accel_event_consts.vh ====
/*
 * Constants for the accelerometer event status and step count register bank:
 * register offsets, bit positions, reset values and field widths.
 * Assumes it is included by bare name from the design files only.
 */
// Function
// - Read-only mirror at 36h: overrun, wake, sleep, double, single, orientation, fall, ready.
// - Overrun flag reads 1 while FIFO is full and a sample was overwritten.
// - New-sample flag reads 1 while fresh X, Y and Z data are available.
// - Read-only wake-up source at 37h: fall, sleep, wake, X, Y, Z wake.
// - Each axis has its own wake-up flag, 1 when wake-up seen on it.
// - Read-only knock source at 38h: any, single, double, sign, X, Y, Z.
// - Knock polarity reads 0 for positive and 1 for negative acceleration.
// - Each axis has its own knock flag, 1 when knock seen on it.
// - Read-only orientation source at 39h: change, then Z, Y, X high and low bits.
// - Orientation change flag reads 1 when a position change is detected.
// - Each directional bit reads 1 while that direction exceeds threshold.
// - Step threshold register at 3Ah: clear, 4 g mode, threshold defaulting 10h.
// - Writing 1 to clear bit synchronously zeroes step count; bit defaults 0.
// - 4 g mode bit enables wide pedometer range when 1; default 0.
// - Low byte of unsigned step count reads at 3Bh.
// - High byte of step count reads at 3Ch, forming a 16-bit count.
`ifndef ACCEL_EVENT_CONSTS_VH
`define ACCEL_EVENT_CONSTS_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define OFS_EVENT_STATUS_MIRROR  8'h36
`define OFS_WAKEUP_SOURCE        8'h37
`define OFS_KNOCK_SOURCE         8'h38
`define OFS_ORIENTATION_SOURCE   8'h39
`define OFS_STEP_THRESHOLD_CFG   8'h3A
`define OFS_STEP_COUNT_LOW       8'h3B
`define OFS_STEP_COUNT_HIGH      8'h3C

// ********************************************************************
// Event flag vector positions (one shared source per event)
// ********************************************************************
`define EV_OVERRUN      0
`define EV_NEW_SAMPLE   1
`define EV_WAKEUP       2
`define EV_WAKE_X       3
`define EV_WAKE_Y       4
`define EV_WAKE_Z       5
`define EV_SLEEP        6
`define EV_FREEFALL     7
`define EV_KNOCK_ANY    8
`define EV_KNOCK_SINGLE 9
`define EV_KNOCK_DOUBLE 10
`define EV_KNOCK_NEG    11
`define EV_KNOCK_X      12
`define EV_KNOCK_Y      13
`define EV_KNOCK_Z      14
`define EV_ORIENT_CHG   15
`define EV_X_LOW        16
`define EV_X_HIGH       17
`define EV_Y_LOW        18
`define EV_Y_HIGH       19
`define EV_Z_LOW        20
`define EV_Z_HIGH       21
`define EV_WIDTH        22

// ********************************************************************
// Step threshold configuration fields and reset values
// ********************************************************************
`define STC_CLEAR_BIT     7
`define STC_WIDE_BIT      6
`define STC_THRESH_MSB    5
`define STC_THRESH_RESET  6'h10
`define STEP_COUNT_WIDTH  16

`endif

// ==== logic/step_tally.v ====
/*
 * Sixteen-bit unsigned step tally with synchronous clear.
 * Assumes step pulses are one cycle wide and come from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "accel_event_consts.vh"

module step_tally
(
    input  wire                            sys_clk,
    input  wire                            resetn,
    input  wire                            step_pulse,
    input  wire                            clear,
    output reg  [`STEP_COUNT_WIDTH-1:0]    count
);

    reg [`STEP_COUNT_WIDTH-1:0] count_next;

    // Clear wins over a coincident step so the count reads zero afterwards
    always @*
    begin
        count_next = count;
        if (clear)
        begin
            count_next = {`STEP_COUNT_WIDTH{1'b0}};
        end
        else if (step_pulse)
        begin
            // Wraps at full scale; software samples often enough to see it
            count_next = count + {{(`STEP_COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Count register
    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            count <= {`STEP_COUNT_WIDTH{1'b0}};
        end
        else
        begin
            count <= count_next;
        end
    end

endmodule
`default_nettype wire

// ==== sim/host_port.sv ====
/* Host side of the register port: strobes change on falling edges.
   Assumes the bank samples its port on the rising edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module host_port
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd_en
);
    // Idle at time zero; released lines show the inverse value
    initial {reg_addr, reg_wr_en, reg_wdata, reg_rd_en} = 18'h0;
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_wr_en} = {~a, ~v, 1'b0};
    endtask
    // Read; answer due one cycle on, and no read is used to clear flags
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        {reg_addr, reg_rd_en} = {a, 1'b1};
        @(negedge sys_clk);
        {reg_addr, reg_rd_en} = {~a, 1'b0};
        v = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ==== sim/accel_event_regs_chk.sv ====
/* Port checks for the event register bank.
   Assumes detector inputs are low while resetn is low. */
`timescale 1ns/1ps
`default_nettype none
module accel_event_regs_chk
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic        reg_rd_valid,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        fifo_overrun_det,
    input wire logic        new_sample_det,
    input wire logic        wakeup_det,
    input wire logic        inactivity_det,
    input wire logic        freefall_det,
    input wire logic        x_wakeup_det,
    input wire logic        y_wakeup_det,
    input wire logic        z_wakeup_det,
    input wire logic        knock_det,
    input wire logic        single_knock_det,
    input wire logic        double_knock_det,
    input wire logic        knock_negative_det,
    input wire logic        orientation_change_det,
    input wire logic        x_knock_det,
    input wire logic        y_knock_det,
    input wire logic        z_knock_det,
    input wire logic        z_high_det,
    input wire logic        z_low_det,
    input wire logic        y_high_det,
    input wire logic        y_low_det,
    input wire logic        x_high_det,
    input wire logic        x_low_det,
    input wire logic        step_pulse,
    input wire logic        step_count_clear,
    input wire logic        pedometer_wide_range,
    input wire logic [5:0]  step_min_threshold,
    input wire logic [15:0] step_count
);
    // ********
    // Expected bytes; flags lag detectors by one edge, so reads use depth 2
    // ********
    wire [7:0] mir = {fifo_overrun_det, wakeup_det, inactivity_det, double_knock_det,
                      single_knock_det, orientation_change_det, freefall_det, new_sample_det};
    wire [7:0] wak = {2'h0, freefall_det, inactivity_det, wakeup_det, x_wakeup_det, y_wakeup_det,
                      z_wakeup_det};
    wire [7:0] knk = {1'h0, knock_det | single_knock_det | double_knock_det, single_knock_det,
                      double_knock_det, knock_negative_det, x_knock_det, y_knock_det, z_knock_det};
    wire [7:0] ori = {1'h0, orientation_change_det, z_high_det, z_low_det, y_high_det, y_low_det,
                      x_high_det, x_low_det};
    wire [7:0] cfg = {step_count_clear, pedometer_wide_range, step_min_threshold};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read got no answer");
    a_mirror_read: assert property (reg_rd_en && reg_addr == 8'h36 |=> reg_rdata == $past(mir, 2))
        else $error("mirror read wrong");
    a_wake_read: assert property (reg_rd_en && reg_addr == 8'h37 |=> reg_rdata == $past(wak, 2))
        else $error("wake source read wrong");
    a_knock_read: assert property (reg_rd_en && reg_addr == 8'h38 |=> reg_rdata == $past(knk, 2))
        else $error("knock source read wrong");
    a_orient_read: assert property (reg_rd_en && reg_addr == 8'h39 |=> reg_rdata == $past(ori, 2))
        else $error("orientation source read wrong");
    a_cfg_write: assert property (reg_wr_en && reg_addr == 8'h3A |=> cfg == $past(reg_wdata))
        else $error("config write lost");
    a_cfg_hold: assert property (!(reg_wr_en && reg_addr == 8'h3A) |=> $stable(cfg))
        else $error("config changed unasked");
    a_clear_zero: assert property (step_count_clear |=> step_count == 16'h0)
        else $error("count not held clear");
    a_step_advance: assert property (!step_count_clear |=>
        step_count == $past(step_count) + {15'h0, $past(step_pulse)})
        else $error("count step wrong");
    c_high_read: cover property (reg_rd_en && reg_addr == 8'h3C);
    c_clear_pulse: cover property (step_count_clear && step_pulse);
    c_cfg_write: cover property (reg_wr_en && reg_addr == 8'h3A);
endmodule
bind accel_event_regs accel_event_regs_chk chk (.*);
`default_nettype wire

// ==== sim/test_accel_event_regs.sv ====
/* Bench for the event register bank: random detector levels, config
   writes, step bursts, clear and a mid-run reset.
   Assumes host_port and the bound checker are compiled beforehand. */
`timescale 1ns/1ps
`default_nettype none
module test_accel_event_regs;
    logic        sys_clk, resetn, step_pulse, reg_wr_en, reg_rd_en, reg_rd_valid, step_count_clear;
    logic        pedometer_wide_range;
    logic [21:0] d;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cfg;
    logic [5:0]  step_min_threshold;
    logic [15:0] step_count, cnt;
    int          fail_count = 0, total_checks = 0, cyc = 0, i;
    host_port h (.sys_clk, .reg_rdata, .reg_rd_valid, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en);
    // Detector vector, low bit first in the bank's event order
    accel_event_regs dut
    (
        .sys_clk, .resetn, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid,
        .fifo_overrun_det(d[0]), .new_sample_det(d[1]), .wakeup_det(d[2]), .x_wakeup_det(d[3]),
        .y_wakeup_det(d[4]), .z_wakeup_det(d[5]), .inactivity_det(d[6]), .freefall_det(d[7]),
        .knock_det(d[8]), .single_knock_det(d[9]), .double_knock_det(d[10]),
        .knock_negative_det(d[11]), .x_knock_det(d[12]), .y_knock_det(d[13]), .z_knock_det(d[14]),
        .orientation_change_det(d[15]), .x_low_det(d[16]), .x_high_det(d[17]), .y_low_det(d[18]),
        .y_high_det(d[19]), .z_low_det(d[20]), .z_high_det(d[21]), .step_pulse, .step_count_clear,
        .pedometer_wide_range, .step_min_threshold, .step_count
    );
    // ********
    // Expected register bytes from the detector vector and bench shadows
    // ********
    function automatic logic [7:0] ev(input logic [7:0] a);
        case (a)
            8'h36: return {d[0], d[2], d[6], d[10], d[9], d[15], d[7], d[1]};
            8'h37: return {2'h0, d[7], d[6], d[2], d[3], d[4], d[5]};
            8'h38: return {1'h0, d[8] | d[9] | d[10], d[9], d[10], d[11], d[12], d[13], d[14]};
            8'h39: return {1'h0, d[15], d[21], d[20], d[19], d[18], d[17], d[16]};
            8'h3A: return cfg;
            8'h3B: return cnt[7:0];
            8'h3C: return cnt[15:8];
            default: return 8'h00;
        endcase
    endfunction
    // Read one register and compare
    task automatic rc(input logic [7:0] a);
        logic [7:0] v;
        h.rd(a, v);
        total_checks++;
        if (v !== ev(a))
        begin
            $display("unexpected reg_%h expected %h seen %h", a, ev(a), v);
            fail_count++;
        end
    endtask
    // Back-to-back step pulses; none counts while the clear bit is set
    task automatic steps(input int n);
        repeat (n)
        begin
            @(negedge sys_clk);
            step_pulse = 1'b1;
        end
        @(negedge sys_clk);
        step_pulse = 1'b0;
        cnt += cfg[7] ? 16'h0 : 16'(n);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Hang guard, far past the fewer than nine hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        fail_count += (cyc == 20000);
        if (cyc == 20000)
            wrap_up();
    end
    initial
    begin
        {resetn, step_pulse, d, cfg, cnt} = {24'h0, 8'h10, 16'h0};
        i = $urandom(32'h9268B070);
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        rc(8'h3A);
        rc(8'h3C);
        // All-high and all-low levels first, then random ones
        for (i = 0; i < 40; i++)
        begin
            @(negedge sys_clk);
            d = (i == 0) ? 22'h3FFFFF : (i == 1) ? 22'h0 : 22'($urandom);
            rc(8'h36);
            rc(8'h37);
            rc(8'h38);
            rc(8'h39);
            rc(8'h36);
        end
        h.wr(8'h36, 8'h55);
        rc(8'h36);
        rc(8'h35);
        for (i = 0; i < 6; i++)
        begin
            cfg = (i == 0) ? 8'h7F : {1'b0, 7'($urandom)};
            h.wr(8'h3A, cfg);
            rc(8'h3A);
            // First burst carries into the high byte to exercise the snapshot
            steps((i == 0) ? 260 : 1 + $urandom % 20);
            rc(8'h3B);
            rc(8'h3C);
        end
        {cfg, cnt} = {8'hC5, 16'h0};
        h.wr(8'h3A, cfg);
        steps(3);
        rc(8'h3B);
        cfg = 8'h10;
        h.wr(8'h3A, cfg);
        steps(2);
        rc(8'h3B);
        // Reset in mid-run brings back the defaults
        {resetn, d} = 23'h0;
        @(negedge sys_clk);
        {resetn, cfg, cnt} = {1'b1, 8'h10, 16'h0};
        rc(8'h3A);
        rc(8'h3B);
        wrap_up();
    end
endmodule
`default_nettype wire
